// ===== include/tpt_pkg.sv
// Shared constants and types for the thermal, tracking and loop gain core
package tpt_pkg;
  // Command codes on the management command port
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;
  localparam logic [7:0] CMD_UT_ACTION = 8'h54;
  localparam logic [7:0] CMD_GAIN_RED = 8'hd5;
  localparam logic [7:0] CMD_LOOP_GAIN = 8'hdf;
  localparam logic [7:0] CMD_USER_CFG = 8'he0;
  localparam logic [7:0] CMD_OT_LIMIT = 8'he1;
  localparam logic [7:0] CMD_UT_LIMIT = 8'he2;
  localparam logic [7:0] CMD_OT_WARN = 8'he3;
  localparam logic [7:0] CMD_UT_WARN = 8'he4;
  localparam logic [7:0] CMD_TEMPCO = 8'he5;
  localparam logic [7:0] CMD_EXT_GAIN = 8'he6;
  localparam logic [7:0] CMD_EXT_BIAS = 8'he7;
  localparam logic [7:0] CMD_RETRY_DLY = 8'he8;
  localparam logic [7:0] CMD_STATUS = 8'he9;
  localparam logic [7:0] CMD_EXT_TEMP = 8'hea;

  // Reset values; temperatures are signed whole degrees C
  localparam logic [15:0] OT_LIMIT_RST = 16'h007d;
  localparam logic [15:0] UT_LIMIT_RST = 16'hffd3;
  localparam logic [15:0] OT_WARN_RST = 16'h0073;
  localparam logic [15:0] UT_WARN_RST = 16'hffdd;
  localparam logic [15:0] EXT_GAIN_RST = 16'h0100;
  localparam logic [15:0] EXT_BIAS_RST = 16'h0000;
  localparam logic [7:0] ACTION_RST = 8'h00;
  localparam logic [31:0] LOOP_GAIN_RST = 32'h20400100;
  localparam logic [15:0] GAIN_RED_RST = 16'h0000;
  localparam logic [7:0] USER_CFG_RST = 8'h00;
  localparam logic [8:0] TEMPCO_RST = 9'h000;
  localparam logic [15:0] RETRY_DLY_RST = 16'h0001;
  localparam logic [15:0] TEMPCO_REF_DEGC = 16'h0019;

  // Field positions
  localparam int ACT_RETRY_BIT = 0;
  localparam int TEMPCO_EN_BIT = 8;
  localparam int CAL_SHIFT = 8;
  localparam int TEMPCO_SHIFT = 16;
  localparam int RESID_SHIFT = 8;
  localparam int GR_THR_MSB = 11;
  localparam int GR_DIV_LSB = 12;
  localparam int GR_DIV_MSB = 13;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RETRY_UNIT_NS = 1000000;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_NS / CLK_PERIOD_NS;
  localparam int GR_OBS_CYCLES = 16;

  typedef struct packed {
    logic [2:0] spare;
    logic limitTracked;
    logic ratio100;
    logic ratiometric;
    logic sharedIsTrack;
    logic faultFromExt;
  } tpt_ucfg_t;

  typedef struct packed {
    logic [7:0] integral;
    logic [7:0] residual;
    logic [15:0] gain;
  } tpt_loop_t;

  typedef enum logic [3:0] {
    FLT_RUN = 4'b0001,
    FLT_LATCH = 4'b0010,
    FLT_COOL = 4'b0100,
    FLT_WAIT = 4'b1000
  } tpt_flt_t;
endpackage : tpt_pkg

// ===== verilog/tpt_gain_reduce.sv
// Steady-state proportional gain reduction
`timescale 1ns/1ns
module tpt_gain_reduce
  import tpt_pkg::*;
#(
  parameter int OBS_CYCLES = GR_OBS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cycleStrobe,
  input wire logic signed [15:0] loopError,
  input wire logic [11:0] threshold,
  input wire logic [1:0] divSel,
  input wire logic [15:0] fullGain,
  output logic [15:0] effGain,
  output logic reduced
);
  logic [15:0] quietCount;
  logic [15:0] absErr;
  logic overThr;

  assign absErr = loopError[15] ? 16'(-loopError) : 16'(loopError);
  assign overThr = absErr > {4'h0, threshold};

  // Low-error streak counter, cleared by any loud cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      quietCount <= 16'h0000;
    end else if (cycleStrobe) begin
      if (overThr) begin
        quietCount <= 16'h0000;
      end else if (quietCount != 16'(OBS_CYCLES)) begin
        quietCount <= quietCount + 16'h0001;
      end
    end
  end

  // Loud cycle restores full gain on the same strobe, not after the streak
  always_ff @(posedge clock) begin
    if (rst) begin
      reduced <= 1'b0;
    end else if (cycleStrobe) begin
      if (overThr) begin
        reduced <= 1'b0;
      end else if (quietCount == 16'(OBS_CYCLES - 1)) begin
        reduced <= 1'b1;
      end
    end
  end

  assign effGain = reduced ? (fullGain >> divSel) : fullGain;
endmodule : tpt_gain_reduce

// ===== verilog/tpt_core.sv
// Thermal protection, voltage tracking and loop gain core
// Contract
// - User config picks internal or external temperature for thermal faults.
// - Crossing over or under temperature limit runs that fault's response.
// - Latch response keeps both switch drives off until disable then enable.
// - Retry response waits for warn limit recross, then delay, then restarts.
// - Reset loads over limit +125 C and under limit -45 C.
// - User config selects shared input as external temperature or track reference.
// - Temperature coefficient setup enables winding-resistance current correction.
// - External temperature gets programmable scale and offset before use.
// - Tracking mode uses digitized shared input as output reference.
// - Coincident mode follows tracked voltage until commanded voltage reached.
// - Ratiometric mode follows 50% or 100% of tracked voltage, 50% default.
// - Tracking skips turn-on delay and rise time, keeps power-good delay.
// - Tracking ignores sequenced enable and sequenced disable events.
// - Limit option caps at own target or tracked voltage, freezing target.
// - Prebiased track input: ramp at transition rate up to proper ratio.
// - Loop word: [15:0] gain, [31:24] integral, [23:16] residual.
// - Residual correction acts one switching cycle after proportional effect.
// - Low error at or below [11:0] threshold over period shifts gain right by [13:12].
// - Any cycle above threshold restores full gain at once.
`timescale 1ns/1ns
module tpt_core
  import tpt_pkg::*;
#(
  parameter int RETRY_TICK = RETRY_UNIT_CYCLES,
  parameter int OBS_CYCLES = GR_OBS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdWdata,
  output logic [31:0] cmdRdata,
  output logic cmdAck,
  input wire logic enablePin,
  input wire logic seqOn,
  input wire logic seqOff,
  input wire logic signed [15:0] dieTemp,
  input wire logic signed [15:0] sharedSample,
  input wire logic [15:0] targetVolt,
  input wire logic [15:0] transitionStep,
  input wire logic switchCycle,
  input wire logic signed [15:0] loopError,
  input wire logic signed [15:0] pulseDeviation,
  input wire logic signed [15:0] senseCurrentRaw,
  output logic highSideAllowed,
  output logic lowSideAllowed,
  output logic regulate,
  output logic trackActive,
  output logic skipSoftStart,
  output logic [15:0] refVolt,
  output logic signed [15:0] extTempCal,
  output logic signed [15:0] senseCurrentCorr,
  output logic [15:0] propGain,
  output logic [7:0] integralGain,
  output logic signed [15:0] residualTerm
);
  logic [7:0] otAction;
  logic [7:0] utAction;
  logic [15:0] gainRedCfg;
  tpt_loop_t loopCfg;
  tpt_ucfg_t userCfg;
  logic signed [15:0] otLimit;
  logic signed [15:0] utLimit;
  logic signed [15:0] otWarn;
  logic signed [15:0] utWarn;
  logic [8:0] tempcoCfg;
  logic signed [15:0] extGain;
  logic signed [15:0] extBias;
  logic [15:0] retryDelay;
  logic enMeta;
  logic enSync;
  logic enPrev;
  logic seqGo;
  tpt_flt_t fltState;
  logic fromOver;
  logic [31:0] tickCount;
  logic [15:0] unitCount;
  logic signed [15:0] monTemp;
  logic overHit;
  logic underHit;
  logic signed [31:0] scaled;
  logic signed [15:0] deltaT;
  logic signed [40:0] tcProduct;
  logic [15:0] trackVolt;
  logic [15:0] ratioGoal;
  logic [15:0] frozenTarget;
  logic [15:0] capTarget;
  logic [15:0] trackGoal;
  logic catchUp;
  logic coinDone;
  logic signed [15:0] devPrev;
  logic signed [31:0] residProd;
  logic running;

  // Management commands: writes land one edge after the request
  always_ff @(posedge clock) begin
    if (rst) begin
      otAction <= ACTION_RST;
      utAction <= ACTION_RST;
      gainRedCfg <= GAIN_RED_RST;
      loopCfg <= LOOP_GAIN_RST;
      userCfg <= USER_CFG_RST;
      otLimit <= OT_LIMIT_RST;
      utLimit <= UT_LIMIT_RST;
      otWarn <= OT_WARN_RST;
      utWarn <= UT_WARN_RST;
      tempcoCfg <= TEMPCO_RST;
      extGain <= EXT_GAIN_RST;
      extBias <= EXT_BIAS_RST;
      retryDelay <= RETRY_DLY_RST;
    end else if (cmdValid && cmdWrite) begin
      if (cmdCode == CMD_OT_ACTION) begin
        otAction <= cmdWdata[7:0];
      end else if (cmdCode == CMD_UT_ACTION) begin
        utAction <= cmdWdata[7:0];
      end else if (cmdCode == CMD_GAIN_RED) begin
        gainRedCfg <= cmdWdata[15:0];
      end else if (cmdCode == CMD_LOOP_GAIN) begin
        loopCfg <= cmdWdata;
      end else if (cmdCode == CMD_USER_CFG) begin
        userCfg <= cmdWdata[7:0];
      end else if (cmdCode == CMD_OT_LIMIT) begin
        otLimit <= cmdWdata[15:0];
      end else if (cmdCode == CMD_UT_LIMIT) begin
        utLimit <= cmdWdata[15:0];
      end else if (cmdCode == CMD_OT_WARN) begin
        otWarn <= cmdWdata[15:0];
      end else if (cmdCode == CMD_UT_WARN) begin
        utWarn <= cmdWdata[15:0];
      end else if (cmdCode == CMD_TEMPCO) begin
        tempcoCfg <= cmdWdata[8:0];
      end else if (cmdCode == CMD_EXT_GAIN) begin
        extGain <= cmdWdata[15:0];
      end else if (cmdCode == CMD_EXT_BIAS) begin
        extBias <= cmdWdata[15:0];
      end else if (cmdCode == CMD_RETRY_DLY) begin
        retryDelay <= cmdWdata[15:0];
      end
    end
  end

  // Read data registered; unknown codes read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      cmdRdata <= 32'h00000000;
      cmdAck <= 1'b0;
    end else begin
      cmdAck <= cmdValid;
      if (cmdValid && !cmdWrite) begin
        if (cmdCode == CMD_OT_ACTION) begin
          cmdRdata <= {24'h000000, otAction};
        end else if (cmdCode == CMD_UT_ACTION) begin
          cmdRdata <= {24'h000000, utAction};
        end else if (cmdCode == CMD_GAIN_RED) begin
          cmdRdata <= {16'h0000, gainRedCfg};
        end else if (cmdCode == CMD_LOOP_GAIN) begin
          cmdRdata <= loopCfg;
        end else if (cmdCode == CMD_USER_CFG) begin
          cmdRdata <= {24'h000000, userCfg};
        end else if (cmdCode == CMD_OT_LIMIT) begin
          cmdRdata <= {16'h0000, otLimit};
        end else if (cmdCode == CMD_UT_LIMIT) begin
          cmdRdata <= {16'h0000, utLimit};
        end else if (cmdCode == CMD_OT_WARN) begin
          cmdRdata <= {16'h0000, otWarn};
        end else if (cmdCode == CMD_UT_WARN) begin
          cmdRdata <= {16'h0000, utWarn};
        end else if (cmdCode == CMD_TEMPCO) begin
          cmdRdata <= {23'h000000, tempcoCfg};
        end else if (cmdCode == CMD_EXT_GAIN) begin
          cmdRdata <= {16'h0000, extGain};
        end else if (cmdCode == CMD_EXT_BIAS) begin
          cmdRdata <= {16'h0000, extBias};
        end else if (cmdCode == CMD_RETRY_DLY) begin
          cmdRdata <= {16'h0000, retryDelay};
        end else if (cmdCode == CMD_STATUS) begin
          cmdRdata <= {24'h000000, fromOver, catchUp, coinDone, trackActive, fltState};
        end else if (cmdCode == CMD_EXT_TEMP) begin
          cmdRdata <= {16'h0000, extTempCal};
        end else begin
          cmdRdata <= 32'h00000000;
        end
      end
    end
  end

  // Enable pin is asynchronous to us
  always_ff @(posedge clock) begin
    if (rst) begin
      enMeta <= 1'b0;
      enSync <= 1'b0;
      enPrev <= 1'b0;
    end else begin
      enMeta <= enablePin;
      enSync <= enMeta;
      enPrev <= enSync;
    end
  end

  // External temperature calibration
  assign scaled = sharedSample * extGain;
  always_ff @(posedge clock) begin
    if (rst) begin
      extTempCal <= 16'h0000;
    end else if (!userCfg.sharedIsTrack) begin
      extTempCal <= 16'(scaled >>> CAL_SHIFT) + extBias;
    end
  end

  // Winding resistance drift correction against the calibrated reading
  assign deltaT = extTempCal - TEMPCO_REF_DEGC;
  assign tcProduct = senseCurrentRaw * $signed({1'b0, tempcoCfg[7:0]}) * deltaT;
  always_ff @(posedge clock) begin
    if (rst) begin
      senseCurrentCorr <= 16'h0000;
    end else if (tempcoCfg[TEMPCO_EN_BIT] && !userCfg.sharedIsTrack) begin
      senseCurrentCorr <= senseCurrentRaw + 16'(tcProduct >>> TEMPCO_SHIFT);
    end else begin
      senseCurrentCorr <= senseCurrentRaw;
    end
  end

  // Without an external reading the die sensor is the only valid source
  assign monTemp = (userCfg.faultFromExt && !userCfg.sharedIsTrack) ? extTempCal : dieTemp;
  assign overHit = monTemp > otLimit;
  assign underHit = monTemp < utLimit;

  // Thermal fault response
  always_ff @(posedge clock) begin
    if (rst) begin
      fltState <= FLT_RUN;
      fromOver <= 1'b0;
      tickCount <= 32'h00000000;
      unitCount <= 16'h0000;
    end else begin
      case (fltState)
        FLT_RUN: begin
          if (overHit || underHit) begin
            fromOver <= overHit;
            if (overHit ? otAction[ACT_RETRY_BIT] : utAction[ACT_RETRY_BIT]) begin
              fltState <= FLT_COOL;
            end else begin
              fltState <= FLT_LATCH;
            end
          end
        end
        FLT_LATCH: begin
          if (!enSync && enPrev) begin
            fltState <= FLT_RUN;
          end
        end
        FLT_COOL: begin
          tickCount <= 32'h00000000;
          unitCount <= 16'h0000;
          if (fromOver ? (monTemp < otWarn) : (monTemp > utWarn)) begin
            fltState <= FLT_WAIT;
          end
        end
        FLT_WAIT: begin
          if (tickCount == 32'(RETRY_TICK - 1)) begin
            tickCount <= 32'h00000000;
            unitCount <= unitCount + 16'h0001;
          end else begin
            tickCount <= tickCount + 32'h00000001;
          end
          if (unitCount >= retryDelay) begin
            fltState <= FLT_RUN;
          end
        end
        default: fltState <= FLT_RUN;
      endcase
    end
  end

  // Sequencing events are dropped while tracking
  always_ff @(posedge clock) begin
    if (rst) begin
      seqGo <= 1'b0;
    end else if (!trackActive) begin
      if (seqOn) begin
        seqGo <= 1'b1;
      end else if (seqOff) begin
        seqGo <= 1'b0;
      end
    end
  end

  assign trackActive = userCfg.sharedIsTrack;
  assign skipSoftStart = trackActive;
  assign running = (fltState == FLT_RUN) && enSync && (trackActive || seqGo);
  assign regulate = running;
  assign highSideAllowed = running;
  assign lowSideAllowed = running;

  // Tracking reference; negative samples count as zero
  assign trackVolt = sharedSample[15] ? 16'h0000 : sharedSample;
  assign ratioGoal = (userCfg.ratiometric && !userCfg.ratio100) ? (trackVolt >> 1) : trackVolt;
  assign capTarget = userCfg.limitTracked ? frozenTarget : targetVolt;
  assign trackGoal = (ratioGoal > capTarget) ? capTarget : ratioGoal;

  // Target frozen at enable so later command or margin moves are ignored
  always_ff @(posedge clock) begin
    if (rst) begin
      frozenTarget <= 16'h0000;
    end else if (enSync && !enPrev) begin
      frozenTarget <= targetVolt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refVolt <= 16'h0000;
      catchUp <= 1'b0;
      coinDone <= 1'b0;
    end else if (!trackActive) begin
      refVolt <= targetVolt;
      catchUp <= 1'b0;
      coinDone <= 1'b0;
    end else if (!running) begin
      refVolt <= 16'h0000;
      coinDone <= 1'b0;
      catchUp <= (trackVolt != 16'h0000);
    end else if (catchUp) begin
      if (switchCycle) begin
        if (17'(refVolt) + 17'(transitionStep) >= 17'(trackGoal)) begin
          refVolt <= trackGoal;
          catchUp <= 1'b0;
        end else begin
          refVolt <= refVolt + transitionStep;
        end
      end
    end else if (coinDone) begin
      refVolt <= capTarget;
    end else begin
      refVolt <= trackGoal;
      if (!userCfg.ratiometric && trackGoal == capTarget) begin
        coinDone <= 1'b1;
      end
    end
  end

  // Residual damping uses last cycle's deviation, so first cycle is untouched
  assign residProd = devPrev * $signed({1'b0, loopCfg.residual});
  always_ff @(posedge clock) begin
    if (rst) begin
      devPrev <= 16'h0000;
      residualTerm <= 16'h0000;
    end else if (switchCycle) begin
      devPrev <= pulseDeviation;
      residualTerm <= 16'(residProd >>> RESID_SHIFT);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      integralGain <= 8'h00;
    end else begin
      integralGain <= loopCfg.integral;
    end
  end

  logic [15:0] gainNow;
  tpt_gain_reduce #(
    .OBS_CYCLES(OBS_CYCLES)
  ) gainReduce (
    .clock(clock),
    .rst(rst),
    .cycleStrobe(switchCycle),
    .loopError(loopError),
    .threshold(gainRedCfg[GR_THR_MSB:0]),
    .divSel(gainRedCfg[GR_DIV_MSB:GR_DIV_LSB]),
    .fullGain(loopCfg.gain),
    .effGain(gainNow),
    .reduced()
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      propGain <= 16'h0000;
    end else begin
      propGain <= gainNow;
    end
  end
endmodule : tpt_core

// ===== verification/tpt_core_asserts.sv
// Port-level checker for the thermal, tracking and loop gain core
`timescale 1ns/1ns
module tpt_core_asserts
  import tpt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdWdata,
  input wire logic [31:0] cmdRdata,
  input wire logic cmdAck,
  input wire logic enablePin,
  input wire logic signed [15:0] dieTemp,
  input wire logic switchCycle,
  input wire logic signed [15:0] loopError,
  input wire logic [15:0] propGain,
  input wire logic highSideAllowed,
  input wire logic lowSideAllowed,
  input wire logic trackActive,
  input wire logic skipSoftStart
);
  logic [15:0] otLim;
  logic [15:0] utLim;
  logic [15:0] fullGain;
  logic [11:0] thr;
  tpt_ucfg_t ucfg;
  logic dieSrc;

  // Shadows follow writes so the checks track software changes
  always_ff @(posedge clock) begin
    if (rst) begin
      otLim <= OT_LIMIT_RST;
      utLim <= UT_LIMIT_RST;
      ucfg <= USER_CFG_RST;
    end else if (cmdValid && cmdWrite) begin
      if (cmdCode == CMD_OT_LIMIT) otLim <= cmdWdata[15:0];
      if (cmdCode == CMD_UT_LIMIT) utLim <= cmdWdata[15:0];
      if (cmdCode == CMD_USER_CFG) ucfg <= cmdWdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fullGain <= LOOP_GAIN_RST[15:0];
      thr <= GAIN_RED_RST[11:0];
    end else if (cmdValid && cmdWrite) begin
      if (cmdCode == CMD_LOOP_GAIN) fullGain <= cmdWdata[15:0];
      if (cmdCode == CMD_GAIN_RED) thr <= cmdWdata[11:0];
    end
  end

  // Track mode takes the shared input, so the die sensor is used then
  assign dieSrc = !ucfg.faultFromExt || ucfg.sharedIsTrack;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_pin_low;
    !enablePin [*4];
  endsequence
  sequence s_excess;
    switchCycle && (loopError > $signed({4'h0, thr}) || loopError < -$signed({4'h0, thr}));
  endsequence
  property p_restore;
    s_excess |-> ##[1:3] propGain == fullGain;
  endproperty

  a_ack_follows: assert property (cmdValid |=> cmdAck)
    else $error("command not acknowledged one cycle later");
  a_ack_cause: assert property (cmdAck |-> $past(cmdValid))
    else $error("acknowledge without a command");
  a_limit_read: assert property (cmdValid && !cmdWrite && cmdCode == CMD_OT_LIMIT |=>
      cmdRdata == {16'h0000, otLim})
    else $error("over limit read back wrong");
  a_over_trip: assert property (dieSrc && dieTemp > $signed(otLim) |-> ##[1:2] !highSideAllowed)
    else $error("over temperature did not stop drives");
  a_under_trip: assert property (dieSrc && dieTemp < $signed(utLim) |-> ##[1:2] !highSideAllowed)
    else $error("under temperature did not stop drives");
  a_drive_pair: assert property (highSideAllowed == lowSideAllowed)
    else $error("switch drives disagree");
  a_enable_gate: assert property (s_pin_low |-> !highSideAllowed)
    else $error("drive allowed while disabled");
  a_track_mode: assert property (trackActive == ucfg.sharedIsTrack)
    else $error("track mode does not follow config");
  a_track_skip: assert property (skipSoftStart == trackActive)
    else $error("soft start not skipped in tracking");
  a_gain_restore: assert property (p_restore)
    else $error("full gain not restored after excess");
endmodule : tpt_core_asserts

bind tpt_core tpt_core_asserts tpt_core_asserts_i (
  .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
  .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdAck(cmdAck), .enablePin(enablePin),
  .dieTemp(dieTemp), .switchCycle(switchCycle), .loopError(loopError), .propGain(propGain),
  .highSideAllowed(highSideAllowed), .lowSideAllowed(lowSideAllowed),
  .trackActive(trackActive), .skipSoftStart(skipSoftStart)
);

// ===== verification/test_tpt_core.sv
// Self-checking bench for the thermal, tracking and loop gain core
`timescale 1ns/1ns
module test_tpt_core
  import tpt_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0, cmdWrite = 1'b0, enablePin = 1'b1;
  logic seqOn = 1'b0, seqOff = 1'b0, switchCycle = 1'b0;
  logic [7:0] cmdCode = 8'h00;
  logic [31:0] cmdWdata = 32'h0, cmdRdata, rd;
  logic signed [15:0] dieTemp = 16'sd25, sharedSample = 16'sd0, loopError = 16'sd500;
  logic signed [15:0] pulseDeviation = 16'sd0, senseCurrentRaw = 16'sh1000;
  logic [15:0] targetVolt = 16'h0400, transitionStep = 16'h0010;
  logic cmdAck, highSideAllowed, lowSideAllowed, regulate, trackActive, skipSoftStart;
  logic [15:0] refVolt, propGain;
  logic signed [15:0] extTempCal, senseCurrentCorr, residualTerm;
  logic [7:0] integralGain;
  int err_total = 0, n_checks = 0, cycles = 0;

  initial begin
    forever #20 clock = ~clock;
  end

  // Short retry tick and observation run keep the run brief
  tpt_core #(.RETRY_TICK(4), .OBS_CYCLES(4)) tpt_core_i (
    .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdAck(cmdAck), .enablePin(enablePin),
    .seqOn(seqOn), .seqOff(seqOff), .dieTemp(dieTemp), .sharedSample(sharedSample),
    .targetVolt(targetVolt), .transitionStep(transitionStep), .switchCycle(switchCycle),
    .loopError(loopError), .pulseDeviation(pulseDeviation),
    .senseCurrentRaw(senseCurrentRaw), .highSideAllowed(highSideAllowed),
    .lowSideAllowed(lowSideAllowed), .regulate(regulate), .trackActive(trackActive),
    .skipSoftStart(skipSoftStart), .refVolt(refVolt), .extTempCal(extTempCal),
    .senseCurrentCorr(senseCurrentCorr), .propGain(propGain), .integralGain(integralGain),
    .residualTerm(residualTerm)
  );

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One command; answer is looked at in its single ack cycle
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [31:0] data);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode <= code;
    cmdWdata <= data;
    @(posedge clock);
    cmdValid <= 1'b0;
    #1;
    chk("ack", {31'h0, cmdAck}, 32'h1);
    rd = cmdRdata;
    @(posedge clock);
  endtask : cmd

  task automatic rdchk(input string what, input logic [7:0] code, input logic [31:0] exp);
    cmd(1'b0, code, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic drv(input logic exp);
    chk("high side", {31'h0, highSideAllowed}, {31'h0, exp});
    chk("low side", {31'h0, lowSideAllowed}, {31'h0, exp});
    chk("regulate", {31'h0, regulate}, {31'h0, exp});
  endtask : drv

  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge clock);
      switchCycle <= 1'b1;
      @(posedge clock);
      switchCycle <= 1'b0;
    end
    tick(3);
  endtask : strobe

  task automatic reenable();
    enablePin <= 1'b0;
    tick(6);
    enablePin <= 1'b1;
    tick(6);
  endtask : reenable

  task automatic settle(input logic signed [15:0] t);
    dieTemp <= t;
    tick(4);
  endtask : settle

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    tick(8);
    rst <= 1'b0;
    // Outside tracking the drives wait for a sequenced enable
    seqOn <= 1'b1;
    tick(1);
    seqOn <= 1'b0;
    rdchk("over action", CMD_OT_ACTION, 32'h0);
    rdchk("under action", CMD_UT_ACTION, 32'h0);
    rdchk("loop word", CMD_LOOP_GAIN, 32'h20400100);
    rdchk("over limit", CMD_OT_LIMIT, 32'h0000007d);
    rdchk("under limit", CMD_UT_LIMIT, 32'h0000ffd3);
    rdchk("unmapped", 8'h33, 32'h0);
    drv(1'b1);
    // Limits themselves do not trip
    settle(16'sd125);
    drv(1'b1);
    settle(-16'sd45);
    drv(1'b1);
    settle(16'sd126);
    drv(1'b0);
    settle(16'sd25);
    drv(1'b0);
    reenable();
    drv(1'b1);
    settle(-16'sd46);
    drv(1'b0);
    settle(16'sd25);
    reenable();
    drv(1'b1);
    cmd(1'b1, CMD_OT_ACTION, 32'h1);
    settle(16'sd126);
    drv(1'b0);
    settle(16'sd120);
    tick(16);
    drv(1'b0);
    dieTemp <= 16'sd100;
    tick(2);
    drv(1'b0);
    tick(10);
    drv(1'b1);
    cmd(1'b1, CMD_EXT_GAIN, 32'h200);
    cmd(1'b1, CMD_EXT_BIAS, 32'h5);
    sharedSample <= 16'sd20;
    tick(4);
    chk("ext temp", {16'h0, extTempCal}, 32'h2d);
    cmd(1'b1, CMD_TEMPCO, 32'h110);
    tick(4);
    chk("corrected current", {16'h0, senseCurrentCorr}, 32'h1014);
    cmd(1'b1, CMD_USER_CFG, 32'h1);
    settle(16'sd126);
    drv(1'b1);
    dieTemp <= 16'sd25;
    sharedSample <= 16'sd70;
    tick(4);
    drv(1'b0);
    sharedSample <= 16'sd20;
    tick(12);
    drv(1'b1);
    cmd(1'b1, CMD_USER_CFG, 32'h0);
    cmd(1'b1, CMD_LOOP_GAIN, 32'h7f180200);
    rdchk("loop word", CMD_LOOP_GAIN, 32'h7f180200);
    chk("prop gain", {16'h0, propGain}, 32'h0200);
    chk("integral", {24'h0, integralGain}, 32'h7f);
    pulseDeviation <= 16'sh0100;
    strobe(1);
    chk("residual", {16'h0, residualTerm}, 32'h0);
    pulseDeviation <= 16'sh0000;
    strobe(1);
    chk("residual", {16'h0, residualTerm}, 32'h18);
    // Threshold 10, divide by two; error equal to it still counts as quiet
    cmd(1'b1, CMD_GAIN_RED, 32'h100a);
    loopError <= 16'sd10;
    strobe(3);
    chk("prop gain", {16'h0, propGain}, 32'h0200);
    strobe(2);
    chk("prop gain", {16'h0, propGain}, 32'h0100);
    loopError <= -16'sd11;
    strobe(1);
    chk("prop gain", {16'h0, propGain}, 32'h0200);
    loopError <= 16'sd10;
    strobe(3);
    chk("prop gain", {16'h0, propGain}, 32'h0200);
    sharedSample <= 16'sd0;
    cmd(1'b1, CMD_USER_CFG, 32'h6);
    chk("track", {31'h0, trackActive}, 32'h1);
    chk("skip soft start", {31'h0, skipSoftStart}, 32'h1);
    // Enabled long before the track input starts to rise
    sharedSample <= 16'sh0200;
    tick(4);
    chk("ref half", {16'h0, refVolt}, 32'h0100);
    cmd(1'b1, CMD_USER_CFG, 32'he);
    tick(2);
    chk("ref full", {16'h0, refVolt}, 32'h0200);
    seqOff <= 1'b1;
    tick(1);
    seqOff <= 1'b0;
    tick(4);
    drv(1'b1);
    cmd(1'b1, CMD_USER_CFG, 32'h2);
    tick(2);
    chk("ref coincident", {16'h0, refVolt}, 32'h0200);
    sharedSample <= 16'sh0500;
    tick(4);
    chk("ref capped", {16'h0, refVolt}, 32'h0400);
    // Tracked-voltage cap ignores a new commanded voltage
    cmd(1'b1, CMD_USER_CFG, 32'h12);
    targetVolt <= 16'h0300;
    tick(2);
    chk("ref frozen", {16'h0, refVolt}, 32'h0400);
    // Prebiased track input: catch-up steps only on switch cycles
    reenable();
    chk("ref catch-up start", {16'h0, refVolt}, 32'h0);
    rdchk("status", CMD_STATUS, 32'hd1);
    strobe(2);
    chk("ref catch-up step", {16'h0, refVolt}, 32'h0020);
    cmd(1'b1, CMD_OT_LIMIT, 32'h64);
    rdchk("over limit", CMD_OT_LIMIT, 32'h64);
    sharedSample <= 16'sd0;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdchk("over limit", CMD_OT_LIMIT, 32'h0000007d);
    close_out();
  end
endmodule : test_tpt_core
